// ---- shared/adcfe_pkg.sv ----
// adcfe_pkg: constants, register offsets and carrier types of the channel front-end control.
// assumes one system clock; offsets are byte addresses on the plain register port.
package adcfe_pkg;
   localparam int          ADCFE_NCH         = 4;
   localparam int          ADCFE_DATA_W      = 24;
   localparam int          ADCFE_ADDR_W      = 8;
   // modulator runs at the master clock divided by this
   localparam int          ADCFE_MOD_DIV     = 2;
   localparam logic [15:0] ADCFE_OSR_MIN     = 16'h0080;
   localparam logic [2:0]  ADCFE_OSR_DEFAULT = 3'h3;
   localparam logic [4:0]  ADCFE_RAW_SHIFT   = 5'h0F;
   localparam int          ADCFE_GCAL_FRAC   = 15;
   localparam int          ADCFE_REF_MV      = 1200;
   // gain code n means gain 2**n; precharge from code 3 (gain 8) upward
   localparam logic [2:0]  ADCFE_GAIN_RESET  = 3'h0;
   localparam logic [2:0]  ADCFE_PRECHG_CODE = 3'h3;
   localparam logic [15:0] ADCFE_GCAL_RESET  = 16'h8000;
   localparam logic [23:0] ADCFE_OFS_RESET   = 24'h000000;
   localparam logic [7:0]  ADCFE_PHASE_RESET = 8'h00;
   // register offsets
   localparam logic [7:0]  ADCFE_CLKCFG_OFS  = 8'h00;
   localparam logic [7:0]  ADCFE_GAIN_OFS    = 8'h04;
   localparam logic [7:0]  ADCFE_STATUS_OFS  = 8'h08;
   localparam logic [3:0]  ADCFE_CHCFG_RGN   = 4'h1;
   localparam logic [3:0]  ADCFE_OFSCAL_RGN  = 4'h2;
   localparam logic [3:0]  ADCFE_GCAL_RGN    = 4'h3;
   localparam logic [3:0]  ADCFE_DATA_RGN    = 4'h4;
   // field positions
   localparam int          ADCFE_PWR_LSB     = 0;
   localparam int          ADCFE_OSR_LSB     = 2;
   localparam int          ADCFE_GAIN_FLD_W  = 3;
   localparam int          ADCFE_INSEL_LSB   = 0;
   localparam int          ADCFE_PHASE_LSB   = 8;

   typedef enum logic [1:0] {
      ADCFE_PWR_VLP = 2'b00,
      ADCFE_PWR_LP  = 2'b01,
      ADCFE_PWR_HR  = 2'b10
   } adcfe_pwr_t;

   typedef enum logic [1:0] {
      ADCFE_IN_PINS = 2'b00,
      ADCFE_IN_GND  = 2'b01,
      ADCFE_IN_TPOS = 2'b10,
      ADCFE_IN_TNEG = 2'b11
   } adcfe_insel_t;

   typedef struct packed {
      logic [2:0] osr;
      logic [1:0] pwr;
   } adcfe_clkcfg_t;

   typedef struct packed {
      logic [7:0]   phase;
      adcfe_insel_t insel;
   } adcfe_chcfg_t;

   localparam adcfe_clkcfg_t ADCFE_CLKCFG_RESET = '{osr: ADCFE_OSR_DEFAULT, pwr: ADCFE_PWR_HR};
endpackage

// ---- verilog/adcfe_decim.sv ----
// adcfe_decim: one channel's decimator with phase start, offset and gain correction.
// assumes modulator bits arrive on the system clock, sampled when mod_en is high.
`timescale 1ns/1ps
module adcfe_decim import adcfe_pkg::*; #(
   parameter int DW = ADCFE_DATA_W
)(
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rst_n,
   // timing
   input  wire logic          mod_en,
   input  wire logic          restart,
   input  wire logic [2:0]    osr_sel,
   input  wire logic [7:0]    phase,
   // modulator and calibration
   input  wire logic          mod_bit,
   input  wire logic [DW-1:0] offset,
   input  wire logic [15:0]   gcal,
   // result
   output logic [DW-1:0]      data,
   output logic               valid
);
   logic [14:0]          cnt_reg, cnt_next;
   logic [14:0]          ones_reg, ones_next;
   logic [DW-1:0]        data_reg, data_next;
   logic                 valid_reg, valid_next;
   logic [15:0]          osr;
   logic [14:0]          last;
   logic [15:0]          tot;
   logic signed [DW-1:0] raw, diff;
   logic signed [DW+16:0] prod;

   always_comb begin
      osr        = ADCFE_OSR_MIN << osr_sel;
      last       = 15'(osr - 16'h0001);
      tot        = 16'(ones_reg) + 16'(mod_bit);
      raw        = $signed(DW'({tot, 1'b0}) - DW'(osr)) <<< (ADCFE_RAW_SHIFT - 5'(osr_sel));
      diff       = raw - $signed(offset);
      prod       = diff * $signed({1'b0, gcal});
      cnt_next   = cnt_reg;
      ones_next  = ones_reg;
      data_next  = data_reg;
      valid_next = 1'b0;
      if (restart) begin
         cnt_next  = 15'(phase);
         ones_next = 15'h0000;
      end else if (mod_en) begin
         if (cnt_reg >= last) begin
            cnt_next   = 15'h0000;
            ones_next  = 15'h0000;
            data_next  = DW'(prod >>> ADCFE_GCAL_FRAC);
            valid_next = 1'b1;
         end else begin
            cnt_next  = cnt_reg + 15'h0001;
            ones_next = 15'(tot);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_reg   <= 15'h0000;
         ones_reg  <= 15'h0000;
         data_reg  <= '0;
         valid_reg <= 1'b0;
      end else begin
         cnt_reg   <= cnt_next;
         ones_reg  <= ones_next;
         data_reg  <= data_next;
         valid_reg <= valid_next;
      end
   end

   assign data  = data_reg;
   assign valid = valid_reg;

   a_restart_phase: assert property (@(posedge clk) disable iff (!rst_n)
      restart |=> cnt_reg == 15'($past(phase)))
      else $error("restart did not load the phase start count");
   a_period_end: assert property (@(posedge clk) disable iff (!rst_n)
      valid_reg |-> $past(mod_en) && !$past(restart) && $past(cnt_reg) >= $past(last))
      else $error("sample produced outside the end of a decimation period");
endmodule

// ---- verilog/adcfe_ctrl.sv ----
// adcfe_ctrl: register file and timing control of the multichannel converter front end.
// assumes a plain register port on CLK_SYS and asynchronous SYNC_N and REF_READY pins.
`timescale 1ns/1ps
module adcfe_ctrl import adcfe_pkg::*; #(
   parameter int NCH = ADCFE_NCH,
   parameter int DW  = ADCFE_DATA_W
)(
   // clock and reset
   input  wire logic                    CLK_SYS,
   input  wire logic                    RST_N,
   // register port
   input  wire logic [ADCFE_ADDR_W-1:0] REG_ADDR,
   input  wire logic [31:0]             REG_WDATA,
   input  wire logic                    REG_WR,
   input  wire logic                    REG_RD,
   output logic [31:0]                  REG_RDATA,
   // pins
   input  wire logic                    SYNC_N,
   input  wire logic                    REF_READY,
   // modulators
   input  wire logic [NCH-1:0]          MOD_BIT,
   output logic                         MOD_CLK_EN,
   // analog controls
   output logic [2*NCH-1:0]             CH_INSEL,
   output logic [3*NCH-1:0]             CH_PGA_GAIN,
   output logic [NCH-1:0]               CH_PRECHARGE,
   output logic [1:0]                   BIAS_MODE,
   // samples
   output logic [NCH-1:0]               SAMPLE_STB,
   output logic [NCH*DW-1:0]            SAMPLE_DATA
);
   adcfe_clkcfg_t       clkcfg_reg, clkcfg_next;
   logic [3*NCH-1:0]    gain_reg, gain_next;
   adcfe_chcfg_t        chcfg_reg [NCH], chcfg_next [NCH];
   logic [DW-1:0]       ofs_reg [NCH], ofs_next [NCH];
   logic [15:0]         gcal_reg [NCH], gcal_next [NCH];
   logic [31:0]         rdata_reg, rdata_next;
   logic                mod_en_reg, mod_en_next;
   logic                sync_meta_reg, sync_sync_reg, sync_prev_reg;
   logic                ref_meta_reg, ref_sync_reg;
   logic                ref_ok_reg, ref_ok_next;
   logic                restart;
   logic [NCH-1:0]      dec_valid;
   logic [DW-1:0]       dec_data [NCH];
   logic [1:0]          ch_sel;
   logic [3:0]          rgn;
   logic                word_ok;

   assign ch_sel  = REG_ADDR[3:2];
   assign rgn     = REG_ADDR[7:4];
   assign word_ok = (REG_ADDR[1:0] == 2'h0) && (int'(ch_sel) < NCH);

   // pin synchronisers; logic reads the second stage, and the third for the SYNC_N edge
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         sync_meta_reg <= 1'b1;
         sync_sync_reg <= 1'b1;
         sync_prev_reg <= 1'b1;
         ref_meta_reg  <= 1'b0;
         ref_sync_reg  <= 1'b0;
      end else begin
         sync_meta_reg <= SYNC_N;
         sync_sync_reg <= sync_meta_reg;
         sync_prev_reg <= sync_sync_reg;
         ref_meta_reg  <= REF_READY;
         ref_sync_reg  <= ref_meta_reg;
      end
   end

   assign restart = sync_prev_reg && !sync_sync_reg;

   always_comb begin
      mod_en_next = !mod_en_reg;
      ref_ok_next = ref_ok_reg || ref_sync_reg;
   end

   always_comb begin
      clkcfg_next = clkcfg_reg;
      gain_next   = gain_reg;
      chcfg_next  = chcfg_reg;
      ofs_next    = ofs_reg;
      gcal_next   = gcal_reg;
      rdata_next  = 32'h00000000;
      if (REG_WR) begin
         if (REG_ADDR == ADCFE_CLKCFG_OFS) begin
            clkcfg_next.pwr = REG_WDATA[ADCFE_PWR_LSB +: 2];
            clkcfg_next.osr = REG_WDATA[ADCFE_OSR_LSB +: 3];
         end
         if (REG_ADDR == ADCFE_GAIN_OFS) begin
            gain_next = REG_WDATA[3*NCH-1:0];
         end
         if (word_ok && rgn == ADCFE_CHCFG_RGN) begin
            chcfg_next[ch_sel].insel = adcfe_insel_t'(REG_WDATA[ADCFE_INSEL_LSB +: 2]);
            chcfg_next[ch_sel].phase = REG_WDATA[ADCFE_PHASE_LSB +: 8];
         end
         if (word_ok && rgn == ADCFE_OFSCAL_RGN) begin
            ofs_next[ch_sel] = REG_WDATA[DW-1:0];
         end
         if (word_ok && rgn == ADCFE_GCAL_RGN) begin
            gcal_next[ch_sel] = REG_WDATA[15:0];
         end
      end
      if (REG_RD) begin
         if (REG_ADDR == ADCFE_CLKCFG_OFS) begin
            rdata_next = 32'(clkcfg_reg);
         end else if (REG_ADDR == ADCFE_GAIN_OFS) begin
            rdata_next = 32'(gain_reg);
         end else if (REG_ADDR == ADCFE_STATUS_OFS) begin
            rdata_next = {27'h0000000, sync_sync_reg, 4'h0 | 4'(ref_ok_reg)};
         end else if (word_ok && rgn == ADCFE_CHCFG_RGN) begin
            rdata_next = 32'(chcfg_reg[ch_sel]);
         end else if (word_ok && rgn == ADCFE_OFSCAL_RGN) begin
            rdata_next = 32'(ofs_reg[ch_sel]);
         end else if (word_ok && rgn == ADCFE_GCAL_RGN) begin
            rdata_next = 32'(gcal_reg[ch_sel]);
         end else if (word_ok && rgn == ADCFE_DATA_RGN) begin
            rdata_next = 32'(dec_data[ch_sel]);
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         clkcfg_reg <= ADCFE_CLKCFG_RESET;
         gain_reg   <= {NCH{ADCFE_GAIN_RESET}};
         for (int i = 0; i < NCH; i++) begin
            chcfg_reg[i] <= '{phase: ADCFE_PHASE_RESET, insel: ADCFE_IN_PINS};
            ofs_reg[i]   <= ADCFE_OFS_RESET;
            gcal_reg[i]  <= ADCFE_GCAL_RESET;
         end
         rdata_reg  <= 32'h00000000;
         mod_en_reg <= 1'b0;
         ref_ok_reg <= 1'b0;
      end else begin
         clkcfg_reg <= clkcfg_next;
         gain_reg   <= gain_next;
         chcfg_reg  <= chcfg_next;
         ofs_reg    <= ofs_next;
         gcal_reg   <= gcal_next;
         rdata_reg  <= rdata_next;
         mod_en_reg <= mod_en_next;
         ref_ok_reg <= ref_ok_next;
      end
   end

   for (genvar c = 0; c < NCH; c++) begin : g_ch
      adcfe_decim #(.DW(DW)) u_decim (
         .clk     (CLK_SYS),
         .rst_n   (RST_N),
         .mod_en  (mod_en_reg),
         .restart (restart),
         .osr_sel (clkcfg_reg.osr),
         .phase   (chcfg_reg[c].phase),
         .mod_bit (MOD_BIT[c]),
         .offset  (ofs_reg[c]),
         .gcal    (gcal_reg[c]),
         .data    (dec_data[c]),
         .valid   (dec_valid[c])
      );
      assign CH_INSEL[2*c +: 2] = chcfg_reg[c].insel;
      // code n: gain 2**n, full scale 1.2 V >> n
      assign CH_PGA_GAIN[3*c +: 3] = gain_reg[3*c +: 3];
      assign CH_PRECHARGE[c] = gain_reg[3*c +: 3] >= ADCFE_PRECHG_CODE;
      assign SAMPLE_STB[c] = dec_valid[c] && ref_ok_reg;
      assign SAMPLE_DATA[DW*c +: DW] = dec_data[c];

      a_precharge_ch: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
         CH_PRECHARGE[c] == (CH_PGA_GAIN[3*c +: 3] > 3'h2))
         else $error("precharge of a channel does not follow its gain");
      a_stb_single: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
         SAMPLE_STB[c] |=> !SAMPLE_STB[c])
         else $error("sample strobe longer than one cycle");
      a_stb_no_delay: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
         ref_ok_reg && dec_valid[c] |-> SAMPLE_STB[c])
         else $error("settled sample held back");
      a_data_on_stb: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
         $changed(SAMPLE_DATA[DW*c +: DW]) |-> dec_valid[c])
         else $error("sample data changed without a new sample");
      a_chcfg_read: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
         REG_RD && REG_ADDR == {ADCFE_CHCFG_RGN, 2'(c), 2'h0}
         |=> REG_RDATA[ADCFE_PHASE_LSB +: 8] == $past(chcfg_reg[c].phase))
         else $error("channel phase read back wrong");
      a_ofs_write: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
         REG_WR && REG_ADDR == {ADCFE_OFSCAL_RGN, 2'(c), 2'h0}
         |=> ofs_reg[c] == $past(REG_WDATA[DW-1:0]))
         else $error("offset calibration not taken from write");
   end

   assign MOD_CLK_EN = mod_en_reg;
   assign BIAS_MODE  = (clkcfg_reg.pwr == 2'b11) ? ADCFE_PWR_HR : clkcfg_reg.pwr;
   assign REG_RDATA  = rdata_reg;

   a_mod_half_rate: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      MOD_CLK_EN |=> !MOD_CLK_EN ##1 MOD_CLK_EN)
      else $error("modulator enable is not half the master clock");
   a_insel_write: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      REG_WR && REG_ADDR == {ADCFE_CHCFG_RGN, 4'h0}
      |=> CH_INSEL[1:0] == $past(REG_WDATA[1:0]))
      else $error("channel 0 input selector not taken from write");
   a_gain_fields: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      REG_WR && REG_ADDR == ADCFE_GAIN_OFS
      |=> CH_PGA_GAIN == $past(REG_WDATA[3*NCH-1:0]))
      else $error("gain fields not applied per channel");
   a_gain_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      !(REG_WR && REG_ADDR == ADCFE_GAIN_OFS) |=> $stable(CH_PGA_GAIN))
      else $error("gain changed without a gain write");
   a_precharge_gain: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      REG_WR && REG_ADDR == ADCFE_GAIN_OFS
      |=> CH_PRECHARGE[0] == ($past(REG_WDATA[2:0]) > 3'h2))
      else $error("precharge does not follow gain above 4");
   a_ref_gate: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      !ref_ok_reg |-> SAMPLE_STB == '0)
      else $error("sample released before the reference settled");
   a_ref_sticky: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      ref_ok_reg |=> ref_ok_reg ##1 ref_ok_reg)
      else $error("settled state withdrawn after first result");
   a_bias_mode: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      REG_WR && REG_ADDR == ADCFE_CLKCFG_OFS && REG_WDATA[1:0] != 2'b11
      |=> BIAS_MODE == $past(REG_WDATA[1:0]))
      else $error("power mode not applied");
   a_sync_restart: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      $fell(sync_meta_reg) |=> restart)
      else $error("sync edge did not restart the decimators");
   a_reset_dflt: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      $rose(RST_N) |-> CH_PGA_GAIN == '0 && CH_INSEL == '0)
      else $error("defaults after reset are wrong");
   a_status_read: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      REG_RD && REG_ADDR == ADCFE_STATUS_OFS |=> REG_RDATA[0] == $past(ref_ok_reg))
      else $error("status read does not show reference state");
   a_status_upper: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      REG_RD && REG_ADDR == ADCFE_STATUS_OFS
      |=> REG_RDATA[4] == $past(sync_sync_reg) && REG_RDATA[31:5] == 27'h0000000)
      else $error("status read shows wrong sync level or upper bits");
   a_rdata_idle: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      !REG_RD |=> REG_RDATA == 32'h00000000)
      else $error("read data not zero outside a read");
   a_rdata_gain: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      REG_RD && REG_ADDR == ADCFE_GAIN_OFS |=> REG_RDATA == 32'($past(CH_PGA_GAIN)))
      else $error("gain register read back wrong");
   a_rdata_upper: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      REG_RD && REG_ADDR == ADCFE_CLKCFG_OFS |=> REG_RDATA[31:5] == 27'h0000000)
      else $error("clock configuration read shows upper bits");
   a_unmapped_read: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      REG_RD && REG_ADDR == 8'h0C |=> REG_RDATA == 32'h00000000)
      else $error("unmapped read returned data");
   a_bias_hr_map: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      REG_WR && REG_ADDR == ADCFE_CLKCFG_OFS && REG_WDATA[1:0] == 2'b11
      |=> BIAS_MODE == ADCFE_PWR_HR)
      else $error("unused power code not shown as high resolution");
   a_mod_reset: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      $rose(RST_N) |-> !MOD_CLK_EN)
      else $error("modulator enable high right after reset");
   a_ratio_write: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      REG_WR && REG_ADDR == ADCFE_CLKCFG_OFS
      |=> clkcfg_reg.osr == $past(REG_WDATA[ADCFE_OSR_LSB +: 3]))
      else $error("decimation ratio not taken from write");
   a_insel_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      !(REG_WR && REG_ADDR[7:4] == ADCFE_CHCFG_RGN) |=> $stable(CH_INSEL))
      else $error("input selector changed without a channel write");
   a_ref_path: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      $rose(ref_meta_reg) |-> ##2 ref_ok_reg)
      else $error("settled reference not seen in time");

   c_sample_out: cover property (@(posedge CLK_SYS) disable iff (!RST_N) SAMPLE_STB[0]);
   c_ref_settle: cover property (@(posedge CLK_SYS) disable iff (!RST_N) $rose(ref_ok_reg));
   c_sync_event: cover property (@(posedge CLK_SYS) disable iff (!RST_N) restart);
   c_high_gain:  cover property (@(posedge CLK_SYS) disable iff (!RST_N) CH_PRECHARGE[0]);
endmodule

// ---- testbench/adcfe_mod_model.sv ----
// adcfe_mod_model: stand-in for the four modulator bit streams.
// assumes mod_en from the controller; bits change just after an enabled edge.
`timescale 1ns/1ps
module adcfe_mod_model import adcfe_pkg::*; (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // modulator side
   input  wire logic                 mod_en,
   output logic [ADCFE_NCH-1:0]      mod_bit
);
   logic toggle_reg;
   logic toggle_next;
   always_comb begin
      toggle_next = mod_en ? ~toggle_reg : toggle_reg;
   end
   always_ff @(posedge clk) begin
      toggle_reg <= rst_n ? toggle_next : 1'b0;
   end
   // full positive, full positive, mid scale, full negative
   assign mod_bit = {1'b0, toggle_reg, 1'b1, 1'b1};
endmodule

// ---- testbench/adcfe_ctrl_tb_top.sv ----
// adcfe_ctrl_tb_top: self-checking bench of the converter front-end control.
// assumes the modulator model on the far side; checks outputs, registers and timing.
`timescale 1ns/1ps
module adcfe_ctrl_tb_top;
   import adcfe_pkg::*;
   typedef struct {
      logic [7:0] addr; logic [31:0] wdata; logic [7:0] insel;
      logic [11:0] gain; logic [3:0] pre; logic [1:0] bias;
   } adcfe_row_t;
   adcfe_row_t rows [12] = '{
      '{8'h04, 32'h688, 8'h00, 12'h688, 4'h8, 2'h2},
      '{8'h04, 32'hFAC, 8'h00, 12'hFAC, 4'hF, 2'h2},
      '{8'h04, 32'h690, 8'h00, 12'h690, 4'h8, 2'h2},
      '{8'h10, 32'h003, 8'h03, 12'h690, 4'h8, 2'h2},
      '{8'h14, 32'h002, 8'h0B, 12'h690, 4'h8, 2'h2},
      '{8'h18, 32'h001, 8'h1B, 12'h690, 4'h8, 2'h2},
      '{8'h1C, 32'h000, 8'h1B, 12'h690, 4'h8, 2'h2},
      '{8'h00, 32'h000, 8'h1B, 12'h690, 4'h8, 2'h0},
      '{8'h00, 32'h001, 8'h1B, 12'h690, 4'h8, 2'h1},
      '{8'h00, 32'h003, 8'h1B, 12'h690, 4'h8, 2'h2},
      '{8'h00, 32'h002, 8'h1B, 12'h690, 4'h8, 2'h2},
      '{8'h0C, 32'hFFF, 8'h1B, 12'h690, 4'h8, 2'h2}};
   // ones per 128 modulator ticks; samples are normalised to full scale 2**22
   int ones [4] = '{128, 128, 64, 0};
   int ofs [4]  = '{16, 0, 0, 0};
   int gc [4]   = '{32'h4000, 32'h8000, 32'h8000, 32'h8000};
   logic                  clk_sys, rst_n, reg_wr, reg_rd, sync_n, ref_ready;
   logic [7:0]            reg_addr;
   logic [31:0]           reg_wdata, reg_rdata, d, seen;
   logic [3:0]            mod_bit, sample_stb, ch_precharge;
   logic                  mod_clk_en, p;
   logic [7:0]            ch_insel;
   logic [11:0]           ch_pga_gain;
   logic [1:0]            bias_mode;
   logic [95:0]           sample_data;
   int                    error_cnt, samples_checked, i, n, t0, t1;
   adcfe_ctrl #(.NCH(ADCFE_NCH), .DW(ADCFE_DATA_W)) i_adcfe_ctrl (
      .CLK_SYS(clk_sys), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
      .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .SYNC_N(sync_n),
      .REF_READY(ref_ready), .MOD_BIT(mod_bit), .MOD_CLK_EN(mod_clk_en),
      .CH_INSEL(ch_insel), .CH_PGA_GAIN(ch_pga_gain), .CH_PRECHARGE(ch_precharge),
      .BIAS_MODE(bias_mode), .SAMPLE_STB(sample_stb), .SAMPLE_DATA(sample_data));
   adcfe_mod_model i_adcfe_mod_model (
      .clk(clk_sys), .rst_n(rst_n), .mod_en(mod_clk_en), .mod_bit(mod_bit));
   // master clock runs without gaps at a fixed 10 ns period, whatever the mode
   always #5 clk_sys = ~clk_sys;
   task automatic close_out();
      if (error_cnt == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_sys);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   // bounded wait for a strobe; n is the number of cycles it took
   task automatic wait_stb(input int ch, output int cnt);
      for (cnt = 1; cnt <= 700; cnt++) begin
         @(posedge clk_sys);
         #1;
         if (sample_stb[ch] === 1'b1) return;
      end
      chk(32'h0, 32'h1);
   endtask
   function automatic logic [23:0] samp(input int c);
      longint v;
      v = (longint'(2 * ones[c] - 128) <<< 15) - ofs[c];
      v = (v * gc[c]) >>> 15;
      return v[23:0];
   endfunction
   initial begin
      clk_sys = 1'b0; rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00;
      reg_wdata = 32'h0; sync_n = 1'b1; ref_ready = 1'b0; error_cnt = 0; samples_checked = 0;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      #1;
      chk(32'(ch_insel), 32'h0);
      chk(32'(ch_pga_gain), 32'h0);
      chk(32'(ch_precharge), 32'h0);
      chk(32'(bias_mode), 32'(ADCFE_PWR_HR));
      rd(ADCFE_CLKCFG_OFS, d);
      chk(d, 32'h0E);
      for (i = 0; i < 6; i++) begin
         p = mod_clk_en;
         @(posedge clk_sys);
         #1 chk(32'(mod_clk_en), {31'h0, ~p});
      end
      foreach (rows[k]) begin
         wr(rows[k].addr, rows[k].wdata);
         @(posedge clk_sys);
         #1 chk(32'(ch_insel), 32'(rows[k].insel));
         chk(32'(ch_pga_gain), 32'(rows[k].gain));
         chk(32'(ch_precharge), 32'(rows[k].pre));
         chk(32'(bias_mode), 32'(rows[k].bias));
      end
      // write then read with no gap, data stands one cycle only
      @(posedge clk_sys);
      reg_wr <= 1'b1; reg_addr <= 8'h04; reg_wdata <= 32'h249;
      @(posedge clk_sys);
      reg_wr <= 1'b0; reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, 32'h249);
      @(posedge clk_sys);
      #1 chk(reg_rdata, 32'h0);
      rd(8'h0C, d);
      chk(d, 32'h0);
      wr(8'h04, 32'h690);
      wr(8'h20, 32'h10);
      wr(8'h30, 32'h4000);
      seen = 32'h0;
      for (i = 0; i < 600; i++) begin
         @(posedge clk_sys);
         #1 if (sample_stb !== 4'h0) seen = 32'h1;
      end
      chk(seen, 32'h0);
      @(posedge clk_sys);
      ref_ready <= 1'b1;
      wait_stb(0, n);
      wait_stb(0, n);
      chk(32'(n), 32'd256);
      for (i = 0; i < 4; i++)
         chk(32'(sample_data[24*i+:24]), 32'(samp(i)));
      rd(8'h40, d);
      chk({8'h0, d[23:0]}, 32'(samp(0)));
      rd(ADCFE_STATUS_OFS, d);
      chk({31'h0, d[0]}, 32'h1);
      wr(8'h14, 32'h4002);
      t0 = -1;
      t1 = -1;
      for (i = 0; i < 700; i++) begin
         @(posedge clk_sys);
         sync_n <= (i >= 4);
         #1;
         if (i > 8 && sample_stb[0] === 1'b1 && t0 < 0) t0 = i;
         if (i > 8 && sample_stb[1] === 1'b1 && t1 < 0) t1 = i;
      end
      chk(32'(t0 - t1), 32'd128);
      // ratio code 1: period doubles, full scale stays the same
      wr(ADCFE_CLKCFG_OFS, 32'h06);
      rd(ADCFE_CLKCFG_OFS, d);
      chk(d, 32'h06);
      wait_stb(1, n);
      wait_stb(1, n);
      chk(32'(n), 32'd512);
      chk(32'(sample_data[47:24]), 32'(samp(1)));
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (8) @(posedge clk_sys);
      #1 chk(32'(ch_pga_gain), 32'h0);
      chk(32'(ch_insel), 32'h0);
      close_out();
   end
endmodule
